//--- sne_engine_model.sv
// Behavioural model of the self-timed erase/program engine
`timescale 1ns/1ns

module sne_engine_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_resume,
    input wire logic i_suspend,
    input wire logic i_stop,
    input wire logic [7:0] i_lat,
    input wire logic [7:0] i_halted_any_flag_lat,
    input wire logic i_fail,
    output logic o_done,
    output logic o_err,
    output logic o_halted_any_flag_done
);
    logic run;
    logic halted_any_flag;
    logic [7:0] cnt;
    logic [7:0] scnt;

    // Counts an operation down; a fault lands just before the end
    always_ff @(posedge i_clk_sys) begin
        o_done <= 1'b0;
        o_err <= 1'b0;
        o_halted_any_flag_done <= 1'b0;
        if (i_rst || i_stop) begin
            run <= 1'b0;
            halted_any_flag <= 1'b0;
        end else if (i_start || i_resume) begin
            run <= 1'b1;
            halted_any_flag <= 1'b0;
            cnt <= i_lat;
        end else if (i_suspend && run) begin
            halted_any_flag <= 1'b1;
            scnt <= i_halted_any_flag_lat;
        end else if (halted_any_flag) begin
            scnt <= scnt - 8'h01;
            if (scnt == 8'h01) begin
                o_halted_any_flag_done <= 1'b1;
                halted_any_flag <= 1'b0;
                run <= 1'b0;
            end
        end else if (run) begin
            cnt <= cnt - 8'h01;
            o_err <= i_fail && (cnt == 8'h02);
            if (cnt == 8'h01) begin
                o_done <= 1'b1;
                run <= 1'b0;
            end
        end
    end
endmodule

//--- sne_flags.sv
// Suspend nesting and program/erase error flag logic
// How it works
// - Combined suspend flag sits at bit 7 of status register two.
// - Erase-suspended flag, bit 3 of register five, set on erase suspend.
// - Program-suspended flag, bit 2 of register five, set on program suspend.
// - Combined flag always equals erase-suspended OR program-suspended.
// - Completion of a resumed operation clears its suspended flag.
// - The three flags encode none, program, erase or nested suspension.
// - A program may run, suspend and finish while an erase is suspended.
// - Nesting only erase first, program second; no erase under program.
// - Erase-error flag at bit 4 of register four marks erase faults.
// - Program-error flag at bit 5 of register four marks program faults.
// - Accepting a block or chip erase clears the erase-error flag.
// - Accepting program, OTP, status write or lock clears program error.
// - An error detected during execution sets the matching error flag.
// - Error flags hold through suspension; resume leaves them unchanged.
// - Both error flags are volatile and cleared by any reset.
// - Wake from shallow sleep keeps flags; from ultra sleep clears them.
// - Only erase codes and an erase-stopping terminate set erase error.
// - Only program, OTP, status, lock codes or terminate set program error.
// - Terminate after suspend completed is ignored; flags stay, not busy.
// - Terminate before suspend completes sets error, no suspend flag.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns

module sne_flags
    import sne_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_eng_done,
    input wire logic i_eng_err,
    input wire logic i_eng_halted_any_flag_done,
    output logic o_eng_start,
    output logic o_eng_resume,
    output logic o_eng_suspend,
    output logic o_eng_stop,
    output logic o_busy,
    output logic o_halted_any_flag,
    output logic o_erase_suspended_flag,
    output logic o_program_suspended_flag,
    output logic o_erase_error_flag,
    output logic o_program_error_flag
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations

    sne_op_t op;
    sne_op_t next_op;
    sne_pwr_t pwr;
    sne_cls_t cls;
    logic es, ps, ee, pe;
    logic next_es, next_ps;
    logic pdm, rst_armed;
    logic cmd_wr, take, soft_rst, ultra_wake, int_rst;
    logic start_ok, start_erase, start_prog, start_nv;
    logic resume, suspend, stop, set_ee, set_pe;

    // Engine activity that belongs to erase work
    function automatic logic erase_kind(input sne_op_t s);
        erase_kind = (s == ST_ERASE) || (s == ST_ESUSP);
    endfunction

    // Engine activity that belongs to program-class work
    function automatic logic prog_kind(input sne_op_t s);
        prog_kind = (s == ST_PROG) || (s == ST_PSUSP) || (s == ST_NVREG);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command acceptance

    sne_cmd_class u_cls (
        .i_opcode(i_wdata),
        .o_cls(cls)
    );

    assign cmd_wr = i_wr && (i_addr == OFF_CMD);
    // Asleep, only wake and (shallow) software reset get through
    assign take = cmd_wr && ((pwr == PW_AWAKE) || (cls == CL_WAKE) ||
        ((pwr == PW_SHALLOW) && ((cls == CL_RST_EN) || (cls == CL_RST_DO))));
    assign soft_rst = take && (cls == CL_RST_DO) && rst_armed;
    assign ultra_wake = take && (cls == CL_WAKE) && (pwr == PW_ULTRA);
    assign int_rst = i_rst || soft_rst || ultra_wake;

    // New work only when idle and no program is parked
    assign start_ok = (op == ST_IDLE) && !ps && (pwr == PW_AWAKE);
    assign start_erase = take && (cls == CL_ERASE) && start_ok && !es;
    assign start_prog = take && (cls == CL_PROG) && start_ok;
    assign start_nv = take && (cls == CL_NVREG) && start_ok;
    assign resume = take && (cls == CL_RESUME) && (op == ST_IDLE) &&
        (es || ps);
    assign suspend = take && (cls == CL_SUSPEND) && !i_eng_done &&
        ((op == ST_ERASE) || (op == ST_PROG));
    // Idle (suspend done) and register writes ignore terminate
    assign stop = take && (cls == CL_TERM) && (op != ST_IDLE) &&
        (op != ST_NVREG);

    // Error set terms: only erase or program activity can raise them
    assign set_ee = erase_kind(op) && (i_eng_err || stop);
    assign set_pe = prog_kind(op) && (i_eng_err || stop);

    ////////////////////////////////////////////////////////////////////////
    // Engine activity state

    // Next activity, engine events first, then the command
    always_comb begin
        next_op = op;
        unique case (op)
            ST_IDLE: begin
            end
            ST_ERASE, ST_PROG, ST_NVREG: begin
                if (i_eng_done) begin
                    next_op = ST_IDLE;
                end
            end
            ST_ESUSP, ST_PSUSP: begin
                if (i_eng_halted_any_flag_done || i_eng_done) begin
                    next_op = ST_IDLE;
                end
            end
            default: begin
                next_op = ST_IDLE;
            end
        endcase
        if (start_erase) begin
            next_op = ST_ERASE;
        end else if (start_prog) begin
            next_op = ST_PROG;
        end else if (start_nv) begin
            next_op = ST_NVREG;
        end else if (resume) begin
            next_op = ps ? ST_PROG : ST_ERASE;
        end else if (suspend) begin
            next_op = (op == ST_ERASE) ? ST_ESUSP : ST_PSUSP;
        end else if (stop) begin
            next_op = ST_IDLE;
        end
        if (int_rst) begin
            next_op = ST_IDLE;
        end
    end

    // Activity register and busy
    always_ff @(posedge i_clk_sys) begin
        op <= next_op;
        o_busy <= (next_op != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Suspend flags

    // Suspended flags: set on finished suspend, cleared on end of work
    always_comb begin
        next_es = es;
        next_ps = ps;
        if (erase_kind(op) && (i_eng_done || stop)) begin
            next_es = 1'b0;
        end
        if ((op == ST_ESUSP) && i_eng_halted_any_flag_done && !stop && !i_eng_done) begin
            next_es = 1'b1;
        end
        if ((op == ST_PROG || op == ST_PSUSP) && (i_eng_done || stop)) begin
            next_ps = 1'b0;
        end
        if ((op == ST_PSUSP) && i_eng_halted_any_flag_done && !stop && !i_eng_done) begin
            next_ps = 1'b1;
        end
        if (int_rst) begin
            next_es = RST_FLAG;
            next_ps = RST_FLAG;
        end
    end

    // Flags and their combined view, never host-writable
    always_ff @(posedge i_clk_sys) begin
        es <= next_es;
        ps <= next_ps;
        o_halted_any_flag <= next_es || next_ps;
    end

    assign o_erase_suspended_flag = es;
    assign o_program_suspended_flag = ps;

    ////////////////////////////////////////////////////////////////////////
    // Error flags

    // Erase error: cleared on a new erase, set wins over clear
    always_ff @(posedge i_clk_sys) begin
        if (int_rst) begin
            ee <= RST_FLAG;
        end else if (set_ee) begin
            ee <= 1'b1;
        end else if (start_erase) begin
            ee <= 1'b0;
        end
    end

    // Program error: cleared on program-class command
    always_ff @(posedge i_clk_sys) begin
        if (int_rst) begin
            pe <= RST_FLAG;
        end else if (set_pe) begin
            pe <= 1'b1;
        end else if (start_prog || start_nv) begin
            pe <= 1'b0;
        end
    end

    assign o_erase_error_flag = ee;
    assign o_program_error_flag = pe;

    ////////////////////////////////////////////////////////////////////////
    // Power state, reset arming and control register

    // Sleep entry and exit
    always_ff @(posedge i_clk_sys) begin
        if (int_rst) begin
            pwr <= PW_AWAKE;
        end else if (take && (op == ST_IDLE) && (pwr == PW_AWAKE) &&
                (cls == CL_SLEEP)) begin
            pwr <= pdm ? PW_SHALLOW : PW_ULTRA;
        end else if (take && (op == ST_IDLE) && (pwr == PW_AWAKE) &&
                (cls == CL_ULTRA)) begin
            pwr <= PW_ULTRA;
        end else if (take && (cls == CL_WAKE)) begin
            pwr <= PW_AWAKE;
        end
    end

    // Reset enable must directly precede the reset command
    always_ff @(posedge i_clk_sys) begin
        if (int_rst) begin
            rst_armed <= 1'b0;
        end else if (take) begin
            rst_armed <= (cls == CL_RST_EN);
        end
    end

    // Power-down mode select
    always_ff @(posedge i_clk_sys) begin
        if (int_rst) begin
            pdm <= 1'b0;
        end else if (i_wr && (i_addr == OFF_CTRL)) begin
            pdm <= i_wdata[CTRL_PDM_BIT];
        end
    end

    // Engine command pulses
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_eng_start <= 1'b0;
            o_eng_resume <= 1'b0;
            o_eng_suspend <= 1'b0;
            o_eng_stop <= 1'b0;
        end else begin
            o_eng_start <= !int_rst && (start_erase || start_prog || start_nv);
            o_eng_resume <= !int_rst && resume;
            o_eng_suspend <= !int_rst && suspend;
            o_eng_stop <= !int_rst && stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, data in the cycle after the strobe only

    always_ff @(posedge i_clk_sys) begin
        o_rdata <= RST_DATA;
        if (!i_rst && i_rd) begin
            unique case (i_addr)
                OFF_CTRL: o_rdata[CTRL_PDM_BIT] <= pdm;
                OFF_SR2: o_rdata[SR2_HALTED_BIT] <= o_halted_any_flag;
                OFF_SR4: begin
                    o_rdata[SR4_PE_BIT] <= pe;
                    o_rdata[SR4_EE_BIT] <= ee;
                end
                OFF_SR5: begin
                    o_rdata[SR5_ES_BIT] <= es;
                    o_rdata[SR5_PS_BIT] <= ps;
                end
                OFF_STAT: begin
                    o_rdata[STAT_BUSY_BIT] <= o_busy;
                    o_rdata[STAT_SHALLOW_BIT] <= (pwr == PW_SHALLOW);
                    o_rdata[STAT_ULTRA_BIT] <= (pwr == PW_ULTRA);
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // Erase suspend finishing cleanly
    sequence s_erase_parks;
        (op == ST_ESUSP) && i_eng_halted_any_flag_done && !stop && !i_eng_done &&
            !int_rst;
    endsequence

    // Program suspend finishing cleanly
    sequence s_prog_parks;
        (op == ST_PSUSP) && i_eng_halted_any_flag_done && !stop && !i_eng_done &&
            !int_rst;
    endsequence

    a_halted_is_or: assert property (
        o_halted_any_flag == (es || ps))
        else $error("combined suspend flag differs from OR");

    a_erase_parks: assert property (
        s_erase_parks |=> es && !o_busy && o_halted_any_flag)
        else $error("erase suspend not flagged");

    a_prog_parks: assert property (
        s_prog_parks |=> ps && !o_busy && o_halted_any_flag)
        else $error("program suspend not flagged");

    a_resumed_prog_done: assert property (
        (op == ST_PROG) && ps && i_eng_done && !int_rst |=> !ps)
        else $error("program suspended flag held after completion");

    a_erase_clears_ee: assert property (
        start_erase && !int_rst |=> !ee && o_busy)
        else $error("erase error not cleared by new erase");

    a_prog_clears_pe: assert property (
        (start_prog || start_nv) && !int_rst |=> !pe)
        else $error("program error not cleared by new program");

    a_stop_sets_ee: assert property (
        stop && erase_kind(op) && !int_rst |=> ee && !o_busy && !es)
        else $error("terminate of erase did not raise erase error");

    a_stop_sets_pe: assert property (
        stop && (op == ST_PSUSP) && !int_rst |=> pe && !ps && !o_busy)
        else $error("terminate during program suspend mishandled");

    a_idle_stop_ignored: assert property (
        take && (cls == CL_TERM) && (op == ST_IDLE) && !int_rst |=>
            $stable(es) && $stable(ps) && $stable(ee) && $stable(pe) &&
            !o_busy)
        else $error("terminate after completed suspend had effect");

    a_resume_keeps_err: assert property (
        resume && !int_rst |=> $stable(ee) && $stable(pe) && o_busy)
        else $error("resume altered an error flag");

    a_no_erase_under_prog: assert property (
        ps && !es |-> (op != ST_ERASE) && (op != ST_ESUSP))
        else $error("erase running beneath a suspended program");

    a_reset_clears_err: assert property (
        ultra_wake || soft_rst |=> !ee && !pe && !es && !ps && !o_busy)
        else $error("internal reset left a flag set");
endmodule

//--- sne_flags_test.sv
// Self-checking bench for the suspend nesting and error flag block
`timescale 1ns/1ns

module sne_flags_test
    import sne_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic done, err, sdone, start, resume, halted_any_flag, stop, busy;
    logic halted, es, ps, ee, pe;
    logic [7:0] lat = 8'h06;
    logic [7:0] slat = 8'h04;
    logic fail = 1'b0;
    int errors = 0;
    int n_checks = 0;
    logic [7:0] ecodes [7] = '{8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8, 8'h60,
        8'hC7};
    logic [7:0] pcodes [13] = '{8'h02, 8'hA2, 8'h32, 8'h88, 8'h0A, 8'hAD,
        8'hAF, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6F};
    logic [7:0] quiet [8] = '{8'h03, 8'h75, 8'h7A, 8'h06, 8'h9F, 8'h05,
        8'h84, 8'h36};

    sne_flags i_dut (
        .i_clk_sys(clk),
        .i_rst(rst),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .i_eng_done(done),
        .i_eng_err(err),
        .i_eng_halted_any_flag_done(sdone),
        .o_eng_start(start),
        .o_eng_resume(resume),
        .o_eng_suspend(halted_any_flag),
        .o_eng_stop(stop),
        .o_busy(busy),
        .o_halted_any_flag(halted),
        .o_erase_suspended_flag(es),
        .o_program_suspended_flag(ps),
        .o_erase_error_flag(ee),
        .o_program_error_flag(pe)
    );

    sne_engine_model i_eng (
        .i_clk_sys(clk),
        .i_rst(rst),
        .i_start(start),
        .i_resume(resume),
        .i_suspend(halted_any_flag),
        .i_stop(stop),
        .i_lat(lat),
        .i_halted_any_flag_lat(slat),
        .i_fail(fail),
        .o_done(done),
        .o_err(err),
        .o_halted_any_flag_done(sdone)
    );

    // Free-running system clock
    initial begin
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////

    // Status byte expected at one offset from the four flags
    function automatic logic [7:0] exp_reg(input logic [7:0] a,
            input logic s_e, s_p, e_e, e_p);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFF_SR2) v[SR2_HALTED_BIT] = s_e | s_p;
        if (a == OFF_SR4) begin
            v[SR4_PE_BIT] = e_p;
            v[SR4_EE_BIT] = e_e;
        end
        if (a == OFF_SR5) begin
            v[SR5_ES_BIT] = s_e;
            v[SR5_PS_BIT] = s_p;
        end
        return v;
    endfunction

    task automatic summarize();
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] x,
            input logic [7:0] g);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic chk1(input string nm, input logic x, input logic g);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("Error %s expected %b seen %b", nm, x, g);
        end
    endtask

    // One-cycle register write and read
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Waits for the engine to go quiet, with a bound
    task automatic wait_idle();
        int k = 0;
        repeat (2) @(posedge clk);
        #1;
        while (busy !== 1'b0 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 200) begin
            errors++;
            $display("Error busy expected 0 seen %b", busy);
            summarize();
        end
    endtask

    // Reads status registers two, four and five and compares them and the flag ports
    task automatic chk_flags(input logic s_e, s_p, e_e, e_p);
        logic [7:0] d;
        logic [7:0] offs [3] = '{OFF_SR2, OFF_SR4, OFF_SR5};
        foreach (offs[k]) begin
            bus_rd(offs[k], d);
            chk8("status reg", exp_reg(offs[k], s_e, s_p, e_e, e_p), d);
        end
        chk1("halted", s_e | s_p, halted);
        chk1("es", s_e, es);
        chk1("ps", s_p, ps);
        chk1("ee", e_e, ee);
        chk1("pe", e_p, pe);
    endtask

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        logic [7:0] d;
        logic [7:0] op;
        logic f, x_ee, x_pe;
        int j;
        void'($urandom(32'hFD53));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_flags(0, 0, 0, 0);
        bus_rd(8'h18, d);
        chk8("unmapped", 8'h00, d);
        bus_wr(OFF_SR2, 8'h80);
        chk_flags(0, 0, 0, 0);
        // Every erase and program code, then random picks, random faults
        x_ee = 1'b0;
        x_pe = 1'b0;
        for (int i = 0; i < 30; i++) begin
            j = (i < 20) ? i : int'($urandom_range(0, 19));
            op = (j < 7) ? ecodes[j] : pcodes[j - 7];
            f = 1'($urandom_range(0, 1));
            fail <= f;
            lat <= 8'($urandom_range(4, 20));
            bus_wr(OFF_CMD, op);
            @(posedge clk);
            #1;
            if (j < 7) chk1("ee clear", 1'b0, ee);
            else chk1("pe clear", 1'b0, pe);
            wait_idle();
            if (j < 7) x_ee = f;
            else x_pe = f;
            chk_flags(0, 0, x_ee, x_pe);
        end
        // Both errors set, then commands that must not touch them
        fail <= 1'b1;
        bus_wr(OFF_CMD, 8'h20);
        wait_idle();
        bus_wr(OFF_CMD, 8'h02);
        wait_idle();
        foreach (quiet[k]) bus_wr(OFF_CMD, quiet[k]);
        chk_flags(0, 0, 1, 1);
        // Shallow sleep keeps the errors across wake
        bus_wr(OFF_CTRL, 8'h01);
        bus_wr(OFF_CMD, 8'hB9);
        bus_rd(OFF_STAT, d);
        chk8("stat", 8'(1 << STAT_SHALLOW_BIT), d);
        bus_wr(OFF_CMD, 8'hAB);
        chk_flags(0, 0, 1, 1);
        // Ultra sleep by both routes; wake resets the errors
        for (int i = 0; i < 2; i++) begin
            bus_wr(OFF_CTRL, 8'h00);
            bus_wr(OFF_CMD, (i == 0) ? 8'hB9 : 8'h79);
            bus_rd(OFF_STAT, d);
            chk8("stat", 8'(1 << STAT_ULTRA_BIT), d);
            bus_wr(OFF_CMD, 8'hAB);
            chk_flags(0, 0, 0, 0);
            bus_wr(OFF_CMD, 8'h20);
            wait_idle();
        end
        // Software reset pair
        bus_wr(OFF_CMD, 8'h66);
        bus_wr(OFF_CMD, 8'h99);
        chk_flags(0, 0, 0, 0);
        // Terminate during a running erase, then a running program
        fail <= 1'b0;
        lat <= 8'h28;
        for (int i = 0; i < 2; i++) begin
            bus_wr(OFF_CMD, (i == 0) ? 8'h20 : 8'h02);
            bus_wr(OFF_CMD, 8'hF0);
            wait_idle();
            chk_flags(0, 0, 1, 1'(i));
        end
        // Terminate before the suspend sequence finishes
        slat <= 8'h14;
        bus_wr(OFF_CMD, 8'h02);
        bus_wr(OFF_CMD, 8'h75);
        bus_wr(OFF_CMD, 8'hF0);
        wait_idle();
        chk_flags(0, 0, 1, 1);
        // Nested: erase suspended, program inside it suspended too
        slat <= 8'h04;
        bus_wr(OFF_CMD, 8'h20);
        bus_wr(OFF_CMD, 8'h75);
        wait_idle();
        chk_flags(1, 0, 0, 1);
        bus_wr(OFF_CMD, 8'h02);
        bus_wr(OFF_CMD, 8'h75);
        wait_idle();
        chk_flags(1, 1, 0, 0);
        bus_wr(OFF_CMD, 8'hF0);
        chk_flags(1, 1, 0, 0);
        chk1("busy", 1'b0, busy);
        fail <= 1'b1;
        lat <= 8'h06;
        bus_wr(OFF_CMD, 8'h7A);
        wait_idle();
        chk_flags(1, 0, 0, 1);
        bus_wr(OFF_CMD, 8'h7A);
        wait_idle();
        chk_flags(0, 0, 1, 1);
        // Program-only suspension, resumed before any erase
        fail <= 1'b0;
        lat <= 8'h28;
        bus_wr(OFF_CMD, 8'h02);
        bus_wr(OFF_CMD, 8'h75);
        wait_idle();
        chk_flags(0, 1, 1, 0);
        bus_wr(OFF_CMD, 8'h7A);
        wait_idle();
        chk_flags(0, 0, 1, 0);
        // Hardware reset in mid-run, while a program is running
        bus_wr(OFF_CMD, 8'h02);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_flags(0, 0, 0, 0);
        chk1("busy", 1'b0, busy);
        summarize();
    end
endmodule

//--- sne_pkg.sv
// Constants, types and the command classifier for the suspend/error flags
`timescale 1ns/1ns

package sne_pkg;
    // Register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Byte offsets of the register window
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_SR2 = 8'h08;
    localparam logic [7:0] OFF_SR4 = 8'h0C;
    localparam logic [7:0] OFF_SR5 = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;

    // Field positions
    localparam int unsigned SR2_HALTED_BIT = 7;
    localparam int unsigned SR4_PE_BIT = 5;
    localparam int unsigned SR4_EE_BIT = 4;
    localparam int unsigned SR5_ES_BIT = 3;
    localparam int unsigned SR5_PS_BIT = 2;
    localparam int unsigned CTRL_PDM_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SHALLOW_BIT = 1;
    localparam int unsigned STAT_ULTRA_BIT = 2;

    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic RST_FLAG = 1'b0;

    // Command classes
    typedef enum logic [3:0] {
        CL_NONE = 4'h0,
        CL_ERASE = 4'h1,
        CL_PROG = 4'h2,
        CL_NVREG = 4'h3,
        CL_SUSPEND = 4'h4,
        CL_RESUME = 4'h5,
        CL_TERM = 4'h6,
        CL_RST_EN = 4'h7,
        CL_RST_DO = 4'h8,
        CL_SLEEP = 4'h9,
        CL_ULTRA = 4'hA,
        CL_WAKE = 4'hB
    } sne_cls_t;

    // Activity of the self-timed engine
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ERASE = 3'b001,
        ST_PROG = 3'b010,
        ST_NVREG = 3'b011,
        ST_ESUSP = 3'b100,
        ST_PSUSP = 3'b101
    } sne_op_t;

    // Power state
    typedef enum logic [1:0] {
        PW_AWAKE = 2'b00,
        PW_SHALLOW = 2'b01,
        PW_ULTRA = 2'b10
    } sne_pwr_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module sne_cmd_class
    import sne_pkg::*;
(
    input wire logic [7:0] i_opcode,
    output sne_cls_t o_cls
);
    // Opcode to command class
    always_comb begin
        case (i_opcode)
            8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8,
            8'h60, 8'hC7: o_cls = CL_ERASE;
            8'h02, 8'hA2, 8'h32, 8'h88, 8'h0A,
            8'hAD, 8'hAF: o_cls = CL_PROG;
            8'h9B, 8'h01, 8'h31, 8'h11, 8'h71,
            8'h6F: o_cls = CL_NVREG;
            8'h75, 8'hB0: o_cls = CL_SUSPEND;
            8'h7A, 8'hD0: o_cls = CL_RESUME;
            8'hF0: o_cls = CL_TERM;
            8'h66: o_cls = CL_RST_EN;
            8'h99: o_cls = CL_RST_DO;
            8'hB9: o_cls = CL_SLEEP;
            8'h79: o_cls = CL_ULTRA;
            8'hAB: o_cls = CL_WAKE;
            default: o_cls = CL_NONE;
        endcase
    end
endmodule
